/* File: core/emr_pkg.sv */
package emr_pkg;

   // ----------------------------------------------------------------
   // register map (configuration space byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0]  SYSTEM_ERROR_ENABLE_OFS = 8'hCA;
   localparam logic [7:0]  MGMT_INTR_ENABLE_OFS    = 8'hCC;
   localparam logic [7:0]  CTRL_INTR_ENABLE_OFS    = 8'hCE;
   localparam logic [7:0]  SCRATCHPAD_OFS          = 8'hDE;
   localparam logic [7:0]  ERROR_FLAG_OFS          = 8'hC8;
   localparam logic [7:0]  FUNCTION_COMMAND_OFS    = 8'h04;

   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] REG_RESET               = 16'h0000;
   localparam logic [15:0] SERR_WRITABLE_MASK      = 16'h027F;
   localparam logic [15:0] ECC_WRITABLE_MASK       = 16'h0003;
   localparam logic [15:0] FLAG_IMPLEMENTED_MASK   = 16'h027F;
   localparam int          SERR_GLOBAL_BIT         = 8;
   localparam int          NONMEMORY_LOCK_BIT      = 9;
   localparam int          TARGET_ABORT_BIT        = 6;
   localparam int          UNKNOWN_SPECIAL_BIT     = 5;
   localparam int          OUTSIDE_APERTURE_BIT    = 4;
   localparam int          INVALID_GRAPHICS_BIT    = 3;
   localparam int          BAD_TRANSLATION_BIT     = 2;
   localparam int          MULTIBIT_BIT            = 1;
   localparam int          SINGLEBIT_BIT           = 0;

   // ----------------------------------------------------------------
   // hub interface message kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EMR_MSG_SERR = 2'h0,
      EMR_MSG_SMI  = 2'h1,
      EMR_MSG_SCI  = 2'h2
   } emr_msg_kind_t;

   // configuration access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } emr_cfg_req_t;

   // message toward the hub interface
   typedef struct packed {
      emr_msg_kind_t kind;
      logic [15:0]   cause;
   } emr_msg_t;

endpackage

/* File: core/emr_flag_reg.sv */
// sticky error flags: hardware sets, software clears by writing one
module emr_flag_reg
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // detector events and software clear
   input  wire logic [15:0] i_set,
   input  wire logic [15:0] i_clear,
   // flag state
   output logic [15:0]      o_flags,
   output logic [15:0]      o_rise
);

   logic [15:0] flag_reg;
   logic [15:0] flag_next;

   // set wins over a same-cycle clear
   assign flag_next = ((flag_reg & ~i_clear) | i_set) & emr_pkg::FLAG_IMPLEMENTED_MASK;
   assign o_rise    = flag_next & ~flag_reg;
   assign o_flags   = flag_reg;

   // flag storage
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         flag_reg <= emr_pkg::REG_RESET;
      else
         flag_reg <= flag_next;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sticky_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_set == 16'h0000 && i_clear == 16'h0000) |=> (flag_reg == $past(flag_reg)))
      else $error("flag changed without set or clear");

   set_wins_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_set[emr_pkg::MULTIBIT_BIT] && i_clear[emr_pkg::MULTIBIT_BIT])
      |=> flag_reg[emr_pkg::MULTIBIT_BIT])
      else $error("clear beat a same-cycle set");

endmodule

/* File: core/emr_top.sv */
module emr_top
(
   // clock and reset
   input  wire logic                 i_mclk,
   input  wire logic                 i_reset,
   // configuration space access
   input  wire emr_pkg::emr_cfg_req_t i_cfg,
   output logic [15:0]               o_cfg_rdata,
   output logic                      o_cfg_hit,
   // error detector events, one-cycle pulses
   input  wire logic                 i_nonmemory_lock,
   input  wire logic                 i_target_abort,
   input  wire logic                 i_unknown_special,
   input  wire logic                 i_outside_aperture,
   input  wire logic                 i_invalid_graphics,
   input  wire logic                 i_bad_translation,
   input  wire logic                 i_multibit_error,
   input  wire logic                 i_singlebit_error,
   // hub interface message port
   output logic                      o_msg_valid,
   output emr_pkg::emr_msg_t         o_msg,
   input  wire logic                 i_msg_ready
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [15:0] serr_en_reg;
   logic [15:0] serr_en_next;
   logic [15:0] smi_en_reg;
   logic [15:0] smi_en_next;
   logic [15:0] sci_en_reg;
   logic [15:0] sci_en_next;
   logic [15:0] scratch_reg;
   logic [15:0] scratch_next;
   logic [15:0] fcmd_reg;
   logic [15:0] fcmd_next;
   logic [15:0] flags;
   logic [15:0] rise;
   logic [15:0] flag_set;
   logic [15:0] flag_clear;

   // byte-lane merge of a write into a register, keeping only writable bits
   function automatic logic [15:0] merge_write(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  be,
                                               input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
      return (old_v & ~lanes) | (new_v & lanes);
   endfunction

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire hit_serr  = i_cfg.addr == emr_pkg::SYSTEM_ERROR_ENABLE_OFS;
   wire hit_smi   = i_cfg.addr == emr_pkg::MGMT_INTR_ENABLE_OFS;
   wire hit_sci   = i_cfg.addr == emr_pkg::CTRL_INTR_ENABLE_OFS;
   wire hit_scr   = i_cfg.addr == emr_pkg::SCRATCHPAD_OFS;
   wire hit_flag  = i_cfg.addr == emr_pkg::ERROR_FLAG_OFS;
   wire hit_fcmd  = i_cfg.addr == emr_pkg::FUNCTION_COMMAND_OFS;
   wire any_hit   = hit_serr | hit_smi | hit_sci | hit_scr | hit_flag | hit_fcmd;

   assign o_cfg_hit = any_hit & (i_cfg.rd | i_cfg.wr);

   // next values of the writable registers
   assign serr_en_next = (i_cfg.wr && hit_serr) ?
      merge_write(serr_en_reg, i_cfg.wdata, i_cfg.be, emr_pkg::SERR_WRITABLE_MASK) :
      serr_en_reg;
   assign smi_en_next = (i_cfg.wr && hit_smi) ?
      merge_write(smi_en_reg, i_cfg.wdata, i_cfg.be, emr_pkg::ECC_WRITABLE_MASK) :
      smi_en_reg;
   assign sci_en_next = (i_cfg.wr && hit_sci) ?
      merge_write(sci_en_reg, i_cfg.wdata, i_cfg.be, emr_pkg::ECC_WRITABLE_MASK) :
      sci_en_reg;
   assign scratch_next = (i_cfg.wr && hit_scr) ?
      merge_write(scratch_reg, i_cfg.wdata, i_cfg.be, 16'hFFFF) :
      scratch_reg;
   assign fcmd_next = (i_cfg.wr && hit_fcmd) ?
      merge_write(fcmd_reg, i_cfg.wdata, i_cfg.be, 16'h0001 << emr_pkg::SERR_GLOBAL_BIT) :
      fcmd_reg;

   // write-one-to-clear on the flag register
   assign flag_clear = (i_cfg.wr && hit_flag) ?
      merge_write(16'h0000, i_cfg.wdata, i_cfg.be, 16'hFFFF) : 16'h0000;

   // register updates
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         serr_en_reg <= emr_pkg::REG_RESET;
         smi_en_reg  <= emr_pkg::REG_RESET;
         sci_en_reg  <= emr_pkg::REG_RESET;
         scratch_reg <= emr_pkg::REG_RESET;
         fcmd_reg    <= emr_pkg::REG_RESET;
      end
      else
      begin
         serr_en_reg <= serr_en_next;
         smi_en_reg  <= smi_en_next;
         sci_en_reg  <= sci_en_next;
         scratch_reg <= scratch_next;
         fcmd_reg    <= fcmd_next;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [15:0] rdata_reg;
   wire  [15:0] rdata_mux =
      hit_serr ? serr_en_reg :
      hit_smi  ? smi_en_reg  :
      hit_sci  ? sci_en_reg  :
      hit_scr  ? scratch_reg :
      hit_flag ? flags       :
      hit_fcmd ? fcmd_reg    : 16'h0000;

   // read data is registered, answered one cycle after the request
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         rdata_reg <= emr_pkg::REG_RESET;
      else if (i_cfg.rd)
         rdata_reg <= rdata_mux;
   end
   assign o_cfg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // sticky error flags
   // ----------------------------------------------------------------
   always_comb
   begin
      flag_set = 16'h0000;
      flag_set[emr_pkg::NONMEMORY_LOCK_BIT]   = i_nonmemory_lock;
      flag_set[emr_pkg::TARGET_ABORT_BIT]     = i_target_abort;
      flag_set[emr_pkg::UNKNOWN_SPECIAL_BIT]  = i_unknown_special;
      flag_set[emr_pkg::OUTSIDE_APERTURE_BIT] = i_outside_aperture;
      flag_set[emr_pkg::INVALID_GRAPHICS_BIT] = i_invalid_graphics;
      flag_set[emr_pkg::BAD_TRANSLATION_BIT]  = i_bad_translation;
      flag_set[emr_pkg::MULTIBIT_BIT]         = i_multibit_error;
      flag_set[emr_pkg::SINGLEBIT_BIT]        = i_singlebit_error;
   end

   emr_flag_reg u_flags
   (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_set   (flag_set),
      .i_clear (flag_clear),
      .o_flags (flags),
      .o_rise  (rise)
   );

   // ----------------------------------------------------------------
   // message routing: pending bits per kind, one message per rise
   // ----------------------------------------------------------------
   logic [15:0] serr_pend_reg;
   logic [15:0] serr_pend_next;
   logic [15:0] smi_pend_reg;
   logic [15:0] smi_pend_next;
   logic [15:0] sci_pend_reg;
   logic [15:0] sci_pend_next;

   // bits 9 and 6..0 cover lock, abort, special, aperture, graphics, translation and memory
   wire        serr_global = fcmd_reg[emr_pkg::SERR_GLOBAL_BIT];
   wire [15:0] serr_new = rise & serr_en_reg & {16{serr_global}};
   wire [15:0] smi_new  = rise & smi_en_reg;
   wire [15:0] sci_new  = rise & sci_en_reg;

   // message sender state
   typedef enum logic [1:0] {EMR_IDLE, EMR_SEND} emr_state_t;
   emr_state_t       state_reg;
   emr_state_t       state_next;
   emr_pkg::emr_msg_t msg_reg;
   emr_pkg::emr_msg_t msg_next;

   wire pick_serr = serr_pend_reg != 16'h0000;
   wire pick_smi  = !pick_serr && smi_pend_reg != 16'h0000;
   wire pick_sci  = !pick_serr && !pick_smi && sci_pend_reg != 16'h0000;
   wire take      = state_reg == EMR_IDLE && (pick_serr | pick_smi | pick_sci);
   wire done      = state_reg == EMR_SEND && i_msg_ready;

   // lowest set pending bit of the chosen kind
   function automatic logic [15:0] lowest(input logic [15:0] v);
      return v & (~v + 16'h0001);
   endfunction

   wire [15:0] serr_pick = lowest(serr_pend_reg);
   wire [15:0] smi_pick  = lowest(smi_pend_reg);
   wire [15:0] sci_pick  = lowest(sci_pend_reg);

   // pending bits: new rises join, the taken one leaves
   assign serr_pend_next = (serr_pend_reg & ~((take && pick_serr) ? serr_pick : 16'h0000))
                           | serr_new;
   assign smi_pend_next  = (smi_pend_reg & ~((take && pick_smi) ? smi_pick : 16'h0000))
                           | smi_new;
   assign sci_pend_next  = (sci_pend_reg & ~((take && pick_sci) ? sci_pick : 16'h0000))
                           | sci_new;

   // sender next state and message latch
   always_comb
   begin
      state_next = state_reg;
      msg_next   = msg_reg;
      case (state_reg)
         EMR_IDLE:
         begin
            if (take)
            begin
               state_next = EMR_SEND;
               if (pick_serr)
                  msg_next = '{kind: emr_pkg::EMR_MSG_SERR, cause: serr_pick};
               else if (pick_smi)
                  msg_next = '{kind: emr_pkg::EMR_MSG_SMI, cause: smi_pick};
               else
                  msg_next = '{kind: emr_pkg::EMR_MSG_SCI, cause: sci_pick};
            end
         end
         EMR_SEND:
         begin
            if (done)
               state_next = EMR_IDLE;
         end
         default:
            state_next = EMR_IDLE;
      endcase
   end

   // sender registers
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         state_reg     <= EMR_IDLE;
         msg_reg       <= '{kind: emr_pkg::EMR_MSG_SERR, cause: emr_pkg::REG_RESET};
         serr_pend_reg <= emr_pkg::REG_RESET;
         smi_pend_reg  <= emr_pkg::REG_RESET;
         sci_pend_reg  <= emr_pkg::REG_RESET;
      end
      else
      begin
         state_reg     <= state_next;
         msg_reg       <= msg_next;
         serr_pend_reg <= serr_pend_next;
         smi_pend_reg  <= smi_pend_next;
         sci_pend_reg  <= sci_pend_next;
      end
   end

   assign o_msg_valid = state_reg == EMR_SEND;
   assign o_msg       = msg_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   serr_queued_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (rise[emr_pkg::MULTIBIT_BIT] && serr_en_reg[emr_pkg::MULTIBIT_BIT] && serr_global)
      |=> serr_pend_reg[emr_pkg::MULTIBIT_BIT])
      else $error("enabled multibit error not queued as system error");

   serr_global_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!serr_global && serr_pend_reg == 16'h0000) |=> (serr_pend_reg == 16'h0000))
      else $error("system error queued while globally disabled");

   lock_queued_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_nonmemory_lock && !flags[emr_pkg::NONMEMORY_LOCK_BIT]
       && serr_en_reg[emr_pkg::NONMEMORY_LOCK_BIT] && serr_global)
      |=> serr_pend_reg[emr_pkg::NONMEMORY_LOCK_BIT])
      else $error("non-memory lock not queued");

   special_off_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!serr_en_reg[emr_pkg::UNKNOWN_SPECIAL_BIT] && !serr_pend_reg[emr_pkg::UNKNOWN_SPECIAL_BIT])
      |=> !serr_pend_reg[emr_pkg::UNKNOWN_SPECIAL_BIT])
      else $error("special cycle message while disabled");

   smi_queued_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (rise[emr_pkg::SINGLEBIT_BIT] && smi_en_reg[emr_pkg::SINGLEBIT_BIT])
      |=> smi_pend_reg[emr_pkg::SINGLEBIT_BIT])
      else $error("single-bit error not queued as management message");

   sci_queued_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (rise[emr_pkg::MULTIBIT_BIT] && sci_en_reg[emr_pkg::MULTIBIT_BIT])
      |=> sci_pend_reg[emr_pkg::MULTIBIT_BIT])
      else $error("multibit error not queued as control message");

   msg_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_msg_valid && !i_msg_ready) |=> (o_msg_valid && $stable(o_msg)))
      else $error("message dropped or changed before accepted");

   reserved_zero_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (smi_en_reg[15:2] == 14'h0000) && (sci_en_reg[15:2] == 14'h0000)
      && ((serr_en_reg & ~emr_pkg::SERR_WRITABLE_MASK) == 16'h0000))
      else $error("reserved enable bit set");

   scratch_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_cfg.wr && hit_scr && i_cfg.be == 2'h3) |=> (scratch_reg == $past(i_cfg.wdata)))
      else $error("scratchpad did not store write");

endmodule

/* File: sim/emr_hub_model.sv */
module emr_hub_model
(
   // clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_reset,
   // offered cycles to wait before accepting
   input  wire logic [3:0]        i_stall,
   // message port from the block
   input  wire logic              i_msg_valid,
   input  wire emr_pkg::emr_msg_t i_msg,
   output logic                   o_msg_ready,
   // log of accepted messages
   output logic [7:0]             o_count,
   output emr_pkg::emr_msg_t      o_last
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] wait_reg;

   // accept only once the offer has waited out the stall
   assign o_msg_ready = i_msg_valid && (wait_reg >= i_stall);

   // count waiting cycles and record each accepted message
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         wait_reg <= 4'h0;
         o_count  <= 8'h00;
         o_last   <= 18'h00000;
      end
      else if (o_msg_ready)
      begin
         wait_reg <= 4'h0;
         o_count  <= o_count + 8'h01;
         o_last   <= i_msg;
      end
      else if (i_msg_valid)
         wait_reg <= wait_reg + 4'h1;
   end
endmodule

/* File: sim/test_error_message_routing.sv */
module test_error_message_routing;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [7:0]  FLAG = emr_pkg::ERROR_FLAG_OFS;
   localparam logic [7:0]  FCMD = emr_pkg::FUNCTION_COMMAND_OFS;
   localparam logic [7:0]  SERR = emr_pkg::SYSTEM_ERROR_ENABLE_OFS;
   localparam logic [7:0]  REGS [4] = '{8'hCA, 8'hCC, 8'hCE, 8'hDE};
   localparam logic [15:0] MASKS [4] = '{16'h027F, 16'h0003, 16'h0003, 16'hFFFF};
   localparam int          BITS [8] = '{9, 6, 5, 4, 3, 2, 1, 0};

   logic                  i_mclk;
   logic                  i_reset;
   emr_pkg::emr_cfg_req_t cfg;
   logic [15:0]           rdata;
   logic                  hit;
   logic                  hit_q;
   logic [15:0]           ev;
   logic                  valid;
   emr_pkg::emr_msg_t     msg;
   logic                  ready;
   logic [3:0]            stall;
   logic [7:0]            count;
   emr_pkg::emr_msg_t     last;
   int                    fails;
   int                    n_tests;
   int                    cycles;

   // block under test, detector events taken from one vector by flag bit
   emr_top dut
   (
      .i_mclk             (i_mclk),
      .i_reset            (i_reset),
      .i_cfg              (cfg),
      .o_cfg_rdata        (rdata),
      .o_cfg_hit          (hit),
      .i_nonmemory_lock   (ev[9]),
      .i_target_abort     (ev[6]),
      .i_unknown_special  (ev[5]),
      .i_outside_aperture (ev[4]),
      .i_invalid_graphics (ev[3]),
      .i_bad_translation  (ev[2]),
      .i_multibit_error   (ev[1]),
      .i_singlebit_error  (ev[0]),
      .o_msg_valid        (valid),
      .o_msg              (msg),
      .i_msg_ready        (ready)
   );

   // hub side that takes the messages
   emr_hub_model hub
   (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_stall     (stall),
      .i_msg_valid (valid),
      .i_msg       (msg),
      .o_msg_ready (ready),
      .o_count     (count),
      .o_last      (last)
   );

   // clock and hang guard
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         results();
      end
   end

   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // configuration write, one cycle of request
   task automatic cfg_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
      @(negedge i_mclk);
      cfg = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
      @(negedge i_mclk);
      cfg.wr = 1'b0;
   endtask

   // configuration read, data one cycle later
   task automatic cfg_rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge i_mclk);
      cfg = '{rd: 1'b1, wr: 1'b0, addr: a, be: 2'h3, wdata: 16'h0000};
      #1 hit_q = hit;
      @(negedge i_mclk);
      cfg.rd = 1'b0;
      d = rdata;
   endtask

   // one event pulse, then await a message of kind k or none when k is 3
   task automatic fire(input int b, input logic [1:0] k, input logic [15:0] c);
      logic [7:0] n0;
      n0 = count;
      @(negedge i_mclk);
      ev = 16'h0001 << b;
      @(negedge i_mclk);
      ev = 16'h0000;
      // full wait so that a repeated or extra message is counted too
      repeat (12) @(negedge i_mclk);
      if (k == 2'h3)
      begin
         check({8'h00, count}, {8'h00, n0});
         check({15'h0000, valid}, 16'h0000);
      end
      else
      begin
         check({8'h00, count}, {8'h00, n0 + 8'h01});
         check({14'h0000, last.kind}, {14'h0000, k});
         check(last.cause, c);
      end
   endtask

   // reset values, writable bits, byte lanes, unmapped address
   task automatic t_regs;
      logic [15:0] d;
      for (int i = 0; i < 4; i++)
      begin
         cfg_rd(REGS[i], d);
         check(d, 16'h0000);
         check({15'h0000, hit_q}, 16'h0001);
         cfg_wr(REGS[i], 16'hFFFF, 2'h3);
         cfg_rd(REGS[i], d);
         check(d, MASKS[i]);
         cfg_wr(REGS[i], 16'h0000, 2'h1);
         cfg_rd(REGS[i], d);
         check(d, MASKS[i] & 16'hFF00);
         cfg_wr(REGS[i], 16'h0000, 2'h3);
      end
      cfg_wr(8'hD0, 16'hFFFF, 2'h3);
      cfg_rd(8'hD0, d);
      check(d, 16'h0000);
      check({15'h0000, hit_q}, 16'h0000);
      $display("t_regs done");
   endtask

   // every system-error source with its own enable, then cleared
   task automatic t_serr;
      logic [15:0] d;
      cfg_wr(FCMD, 16'h0100, 2'h3);
      for (int i = 0; i < 8; i++)
      begin
         cfg_wr(SERR, 16'h0001 << BITS[i], 2'h3);
         fire(BITS[i], 2'h0, 16'h0001 << BITS[i]);
         cfg_rd(FLAG, d);
         check(d, 16'h0001 << BITS[i]);
         cfg_wr(FLAG, 16'h0001 << BITS[i], 2'h3);
         cfg_rd(FLAG, d);
         check(d, 16'h0000);
      end
      cfg_wr(SERR, 16'h0000, 2'h3);
      $display("t_serr done");
   endtask

   // global gate off, zero write keeps flag, disabled source, scratchpad
   task automatic t_gate;
      logic [15:0] d;
      cfg_wr(FCMD, 16'h0000, 2'h3);
      cfg_wr(SERR, 16'h0020, 2'h3);
      fire(5, 2'h3, 16'h0000);
      cfg_wr(FLAG, 16'h0000, 2'h3);
      cfg_rd(FLAG, d);
      check(d, 16'h0020);
      cfg_wr(FLAG, 16'h0020, 2'h3);
      cfg_wr(FCMD, 16'h0100, 2'h3);
      cfg_wr(SERR, 16'h0000, 2'h3);
      cfg_wr(8'hDE, 16'hFFFF, 2'h3);
      fire(5, 2'h3, 16'h0000);
      cfg_wr(FLAG, 16'h0020, 2'h3);
      $display("t_gate done");
   endtask

   // management and control messages for both memory errors
   task automatic t_ecc;
      logic [7:0] a;
      for (int i = 0; i < 4; i++)
      begin
         a = (i < 2) ? 8'hCC : 8'hCE;
         cfg_wr(a, 16'h0001 << (i % 2), 2'h3);
         fire(i % 2, (i < 2) ? 2'h1 : 2'h2, 16'h0001 << (i % 2));
         cfg_wr(a, 16'h0000, 2'h3);
         cfg_wr(FLAG, 16'h0003, 2'h3);
      end
      $display("t_ecc done");
   endtask

   // slow hub, then a repeat event while the flag is still set
   task automatic t_sticky;
      logic [15:0] d;
      stall = 4'h3;
      cfg_wr(SERR, 16'h0002, 2'h3);
      fire(1, 2'h0, 16'h0002);
      fire(1, 2'h3, 16'h0000);
      cfg_wr(FLAG, 16'h0002, 2'h3);
      fire(1, 2'h0, 16'h0002);
      // event and write-one clear in the same cycle: the set must win
      @(negedge i_mclk);
      cfg = '{rd: 1'b0, wr: 1'b1, addr: FLAG, be: 2'h3, wdata: 16'h0002};
      ev  = 16'h0002;
      @(negedge i_mclk);
      cfg.wr = 1'b0;
      ev     = 16'h0000;
      cfg_rd(FLAG, d);
      check(d, 16'h0002);
      stall = 4'h0;
      $display("t_sticky done");
   endtask

   // verdict and end of run
   task automatic results;
      $display("comparisons=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // main sequence
   initial
   begin
      i_mclk = 1'b0;
      i_reset = 1'b1;
      cfg = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, be: 2'h0, wdata: 16'h0000};
      ev = 16'h0000;
      stall = 4'h0;
      hit_q = 1'b0;
      fails = 0;
      n_tests = 0;
      cycles = 0;
      repeat (2) @(negedge i_mclk);
      i_reset = 1'b0;
      t_regs();
      t_serr();
      t_gate();
      t_ecc();
      t_sticky();
      results();
   end
endmodule
